// File: mic_host_model.sv
/*
   Serial host model: sends mode-0 frames MSB first, 320 ns link clock.
   Assumes the bench calls send and reads rx_byte after it.
*/
`timescale 1ns/1ns
`default_nettype none
module mic_host_model (
   input  wire logic clock,    // System clock
   output var  logic spi_sck,  // Link clock, low outside frames
   output var  logic spi_cs_n, // Chip select, low
   output var  logic spi_si,   // Data to device
   input  wire logic spi_so,   // Data from device
   input  wire logic spi_so_oe // Device drives data out
);
   logic [7:0] rx_byte = 8'h00; // Last eight bits read back

   // Idle link at time zero
   initial begin
      spi_sck = 1'b0;
      spi_cs_n = 1'b1;
      spi_si = 1'b0;
   end

   // One frame of n bits from the top of bits, then select released
   task automatic send(input logic [63:0] bits, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clock);
         spi_cs_n <= 1'b0;
         spi_si <= bits[63 - i];
         repeat (3) @(posedge clock);
         spi_sck <= 1'b1;
         repeat (4) @(posedge clock);
         // An undriven data line reads inverted, so a lost enable shows
         rx_byte <= {rx_byte[6:0], spi_so_oe ? spi_so : ~spi_so};
         spi_sck <= 1'b0;
      end
      repeat (4) @(posedge clock);
      spi_cs_n <= 1'b1;
      spi_si <= ~spi_si;
      repeat (8) @(posedge clock);
   endtask
endmodule
`default_nettype wire

// File: mic_integrity.sv
/*
   Memory integrity block: double-bit error tracking, unit status query,
   clear command and a word-wide CRC-32C engine with pause and continue,
   all commanded over a single-bit mode-0 serial link.
   Assumes the link pins arrive asynchronously and are much slower than
   clock; memory, error reporter and unit error lookup run on clock.
*/
`include "mic_params.svh"
`timescale 1ns/1ns
`default_nettype none
module mic_integrity
   import mic_pkg::*;
(
   input  wire logic        clock,                   // System clock
   input  wire logic        resetn,                  // Async reset, low
   input  wire logic        spi_sck,                 // Link clock pin
   input  wire logic        spi_cs_n,                // Chip select, low
   input  wire logic        spi_si,                  // Link data in
   output var  logic        spi_so,                  // Link data out
   output var  logic        spi_so_oe,               // Data out enable
   input  wire logic [3:0]  read_latency_code,       // Dummy cycles
   input  wire logic        deep_sleep,              // Deep sleep level
   input  wire logic        ecc_double_evt,          // Double error pulse
   input  wire logic [31:0] ecc_double_unit_addr,    // Its unit address
   output var  logic [23:0] unit_query_addr,         // Queried unit
   input  wire logic        unit_query_err,          // Unit has double
   output var  logic        mem_req,                 // Word read request
   output var  logic [23:0] mem_addr,                // Word byte address
   input  wire logic [31:0] mem_word,                // Word, byte0 low
   input  wire logic        mem_ack,                 // Word valid pulse
   output var  logic        write_latch_clr,         // Clear latch pulse
   output var  logic        double_bit_flag,         // Sticky flag
   output var  logic [15:0] double_error_count,      // Error counter
   output var  logic [31:0] error_unit_address_trap, // First unit
   output var  logic [31:0] checksum_result,         // Checksum
   output var  logic        op_in_progress,          // Busy bit
   output var  logic        checksum_abort_bit,      // Abort bit
   output var  logic        checksum_paused_bit      // Paused bit
);

   // MSB-first word update, no reflection
   function automatic logic [31:0] crc_word(input logic [31:0] c_in,
                                            input logic [31:0] d);
      logic [31:0] c;
      logic        fb;
      c = c_in;
      for (int i = 31; i >= 0; i--) begin
         fb = c[31] ^ d[i];
         c  = {c[30:0], 1'b0} ^ (fb ? `MIC_CRC_POLY : 32'h0000_0000);
      end
      return c;
   endfunction

   // Link pin synchronisers
   logic sck_meta_reg, sck_s_reg, sck_d_reg;
   logic cs_meta_reg, cs_s_reg, cs_d_reg;
   logic si_meta_reg, si_s_reg;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         sck_meta_reg <= 1'b0;
         sck_s_reg    <= 1'b0;
         sck_d_reg    <= 1'b0;
         cs_meta_reg  <= 1'b1;
         cs_s_reg     <= 1'b1;
         cs_d_reg     <= 1'b1;
         si_meta_reg  <= 1'b0;
         si_s_reg     <= 1'b0;
      end else begin
         sck_meta_reg <= spi_sck;
         sck_s_reg    <= sck_meta_reg;
         sck_d_reg    <= sck_s_reg;
         cs_meta_reg  <= spi_cs_n;
         cs_s_reg     <= cs_meta_reg;
         cs_d_reg     <= cs_s_reg;
         si_meta_reg  <= spi_si;
         si_s_reg     <= si_meta_reg;
      end
   end

   logic sck_rise, sck_fall, cs_rise;
   assign sck_rise = sck_s_reg & ~sck_d_reg;
   assign sck_fall = ~sck_s_reg & sck_d_reg;
   assign cs_rise  = cs_s_reg & ~cs_d_reg;

   // Link decoder state
   mic_spi_state_t spi_state_reg, spi_state_next;
   logic [5:0]     bit_cnt_reg, bit_cnt_next;
   logic [3:0]     dummy_cnt_reg, dummy_cnt_next;
   logic [7:0]     op_reg, op_next;
   logic [47:0]    addr_sr_reg, addr_sr_next;
   logic [7:0]     out_sr_reg, out_sr_next;
   logic           out_first_reg, out_first_next;
   logic           so_reg, so_next;
   logic [23:0]    qaddr_reg, qaddr_next;
   logic           clear_pulse_reg, clear_pulse_next;
   logic           run_pulse_reg, run_pulse_next;
   logic           pause_pulse_reg, pause_pulse_next;
   logic           cont_pulse_reg, cont_pulse_next;
   logic [7:0]     op_shift;
   logic [7:0]     status_byte;

   // Opcode shift, frame decode and status byte shift-out
   always_comb begin
      spi_state_next   = spi_state_reg;
      bit_cnt_next     = bit_cnt_reg;
      dummy_cnt_next   = dummy_cnt_reg;
      op_next          = op_reg;
      addr_sr_next     = addr_sr_reg;
      out_sr_next      = out_sr_reg;
      out_first_next   = out_first_reg;
      so_next          = so_reg;
      qaddr_next       = qaddr_reg;
      clear_pulse_next = 1'b0;
      run_pulse_next   = 1'b0;
      pause_pulse_next = 1'b0;
      cont_pulse_next  = 1'b0;
      op_shift         = {op_reg[6:0], si_s_reg};
      status_byte      = 8'h00;
      status_byte[`MIC_UNIT_ERR_BIT] = unit_query_err;
      if (cs_s_reg) begin
         spi_state_next = MIC_SPI_CMD;
         bit_cnt_next   = 6'd0;
         if (cs_rise && bit_cnt_reg == `MIC_CMD_BITS) begin
            clear_pulse_next = (op_reg == `MIC_OP_CLEAR);
            pause_pulse_next = (op_reg == `MIC_OP_PAUSE);
            cont_pulse_next  = (op_reg == `MIC_OP_CONTINUE);
         end
         if (cs_rise && bit_cnt_reg == `MIC_RUN_BITS) begin
            run_pulse_next = (op_reg == `MIC_OP_RUN);
         end
      end else if (sck_rise) begin
         if (bit_cnt_reg != `MIC_BIT_CNT_MAX) begin
            bit_cnt_next = bit_cnt_reg + 6'd1;
         end
         unique case (spi_state_reg)
            MIC_SPI_CMD: begin
               op_next = op_shift;
               if (bit_cnt_reg == `MIC_CMD_BITS - 6'd1) begin
                  if (op_shift == `MIC_OP_UNIT_QUERY ||
                      op_shift == `MIC_OP_RUN) begin
                     spi_state_next = MIC_SPI_ADDR;
                  end else begin
                     spi_state_next = MIC_SPI_IGNORE;
                  end
               end
            end
            MIC_SPI_ADDR: begin
               addr_sr_next = {addr_sr_reg[46:0], si_s_reg};
               if (op_reg == `MIC_OP_UNIT_QUERY &&
                   bit_cnt_reg == `MIC_QUERY_BITS - 6'd1) begin
                  qaddr_next = {addr_sr_reg[22:`MIC_UNIT_LSB_BITS - 1],
                                {`MIC_UNIT_LSB_BITS{1'b0}}};
                  dummy_cnt_next = 4'd0;
                  out_first_next = 1'b1;
                  spi_state_next = (read_latency_code == 4'd0) ?
                                   MIC_SPI_DOUT : MIC_SPI_DUMMY;
               end else if (bit_cnt_reg == `MIC_RUN_BITS - 6'd1) begin
                  spi_state_next = MIC_SPI_IGNORE;
               end
            end
            MIC_SPI_DUMMY: begin
               dummy_cnt_next = dummy_cnt_reg + 4'd1;
               if (dummy_cnt_reg + 4'd1 == read_latency_code) begin
                  spi_state_next = MIC_SPI_DOUT;
               end
            end
            MIC_SPI_DOUT: begin
            end
            MIC_SPI_IGNORE: begin
            end
         endcase
      end else if (sck_fall && spi_state_reg == MIC_SPI_DOUT) begin
         // Beyond the first byte only zeros follow
         if (out_first_reg) begin
            so_next        = status_byte[7];
            out_sr_next    = {status_byte[6:0], 1'b0};
            out_first_next = 1'b0;
         end else begin
            so_next     = out_sr_reg[7];
            out_sr_next = {out_sr_reg[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         spi_state_reg   <= MIC_SPI_CMD;
         bit_cnt_reg     <= 6'd0;
         dummy_cnt_reg   <= 4'd0;
         op_reg          <= 8'h00;
         addr_sr_reg     <= 48'h0000_0000_0000;
         out_sr_reg      <= 8'h00;
         out_first_reg   <= 1'b0;
         so_reg          <= 1'b0;
         qaddr_reg       <= 24'h00_0000;
         clear_pulse_reg <= 1'b0;
         run_pulse_reg   <= 1'b0;
         pause_pulse_reg <= 1'b0;
         cont_pulse_reg  <= 1'b0;
      end else begin
         spi_state_reg   <= spi_state_next;
         bit_cnt_reg     <= bit_cnt_next;
         dummy_cnt_reg   <= dummy_cnt_next;
         op_reg          <= op_next;
         addr_sr_reg     <= addr_sr_next;
         out_sr_reg      <= out_sr_next;
         out_first_reg   <= out_first_next;
         so_reg          <= so_next;
         qaddr_reg       <= qaddr_next;
         clear_pulse_reg <= clear_pulse_next;
         run_pulse_reg   <= run_pulse_next;
         pause_pulse_reg <= pause_pulse_next;
         cont_pulse_reg  <= cont_pulse_next;
      end
   end

   assign spi_so          = so_reg;
   assign spi_so_oe       = ~cs_s_reg && spi_state_reg == MIC_SPI_DOUT;
   assign unit_query_addr = qaddr_reg;

   // Error tracking and checksum engine state
   mic_crc_state_t crc_state_reg, crc_state_next;
   logic           flag_reg, flag_next;
   logic [15:0]    dec_reg, dec_next;
   logic [31:0]    trap_reg, trap_next;
   logic [31:0]    crc_reg, crc_next;
   logic [24:0]    cur_reg, cur_next;
   logic [24:0]    last_reg, last_next;
   logic           pause_pend_reg, pause_pend_next;
   logic           abort_reg, abort_next;
   logic           wl_clr_reg, wl_clr_next;
   logic [24:0]    range_first, range_last, cur_step;
   logic [31:0]    word_in;

   assign range_first = {1'b0, addr_sr_reg[47:24]};
   assign range_last  = {1'b0, addr_sr_reg[23:0]};
   assign cur_step    = cur_reg + `MIC_WORD_STEP;
   assign word_in     = {mem_word[7:0], mem_word[15:8],
                         mem_word[23:16], mem_word[31:24]};

   // Flag, counter, trap and checksum run control
   always_comb begin
      crc_state_next  = crc_state_reg;
      flag_next       = flag_reg;
      dec_next        = dec_reg;
      trap_next       = trap_reg;
      crc_next        = crc_reg;
      cur_next        = cur_reg;
      last_next       = last_reg;
      pause_pend_next = pause_pend_reg;
      abort_next      = abort_reg;
      wl_clr_next     = 1'b0;
      // Clear first so that a same-cycle detection still lands
      if (clear_pulse_reg) begin
         flag_next = 1'b0;
         dec_next  = `MIC_DEC_RESET;
         trap_next = `MIC_TRAP_RESET;
      end
      if (deep_sleep) begin
         dec_next  = `MIC_DEC_RESET;
         trap_next = `MIC_TRAP_RESET;
      end
      if (ecc_double_evt) begin
         flag_next = 1'b1;
         if (!flag_reg || clear_pulse_reg || deep_sleep) begin
            trap_next = ecc_double_unit_addr;
         end
         if (clear_pulse_reg || deep_sleep) begin
            dec_next = 16'h0001;
         end else if (dec_reg != `MIC_DEC_MAX) begin
            dec_next = dec_reg + 16'h0001;
         end
      end
      unique case (crc_state_reg)
         MIC_CRC_IDLE: begin
            if (run_pulse_reg) begin
               crc_next  = `MIC_CRC_RESET;
               cur_next  = range_first;
               last_next = range_last;
               if (range_last < range_first + `MIC_RANGE_MIN) begin
                  abort_next = 1'b1;
               end else begin
                  abort_next     = 1'b0;
                  crc_state_next = MIC_CRC_FETCH;
               end
            end
         end
         MIC_CRC_FETCH: begin
            if (pause_pulse_reg) begin
               pause_pend_next = 1'b1;
            end
            if (mem_ack) begin
               crc_next = crc_word(crc_reg, word_in);
               cur_next = cur_step;
               if (cur_step > last_reg) begin
                  crc_state_next  = MIC_CRC_IDLE;
                  pause_pend_next = 1'b0;
                  wl_clr_next     = 1'b1;
               end else if (pause_pend_reg || pause_pulse_reg) begin
                  crc_state_next  = MIC_CRC_PAUSE;
                  pause_pend_next = 1'b0;
               end
            end
         end
         MIC_CRC_PAUSE: begin
            if (cont_pulse_reg) begin
               crc_state_next = MIC_CRC_FETCH;
            end
         end
      endcase
      if (deep_sleep) begin
         crc_next        = `MIC_CRC_RESET;
         crc_state_next  = MIC_CRC_IDLE;
         pause_pend_next = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         crc_state_reg  <= MIC_CRC_IDLE;
         flag_reg       <= 1'b0;
         dec_reg        <= `MIC_DEC_RESET;
         trap_reg       <= `MIC_TRAP_RESET;
         crc_reg        <= `MIC_CRC_RESET;
         cur_reg        <= 25'h000_0000;
         last_reg       <= 25'h000_0000;
         pause_pend_reg <= 1'b0;
         abort_reg      <= 1'b0;
         wl_clr_reg     <= 1'b0;
      end else begin
         crc_state_reg  <= crc_state_next;
         flag_reg       <= flag_next;
         dec_reg        <= dec_next;
         trap_reg       <= trap_next;
         crc_reg        <= crc_next;
         cur_reg        <= cur_next;
         last_reg       <= last_next;
         pause_pend_reg <= pause_pend_next;
         abort_reg      <= abort_next;
         wl_clr_reg     <= wl_clr_next;
      end
   end

   // Result and status outputs
   assign mem_req                 = crc_state_reg == MIC_CRC_FETCH;
   assign mem_addr                = cur_reg[23:0];
   assign write_latch_clr         = wl_clr_reg;
   assign double_bit_flag         = flag_reg;
   assign double_error_count      = dec_reg;
   assign error_unit_address_trap = trap_reg;
   assign checksum_result         = crc_reg;
   assign op_in_progress          = crc_state_reg == MIC_CRC_FETCH;
   assign checksum_abort_bit      = abort_reg;
   assign checksum_paused_bit     = crc_state_reg == MIC_CRC_PAUSE;

endmodule
`default_nettype wire

// File: mic_integrity_bench.sv
/*
   Self-checking bench of mic_integrity: error tracking, unit query,
   clear, checksum run, pause, continue, abort and deep sleep.
   Assumes mic_host_model drives the link pins.
*/
`include "mic_params.svh"
`timescale 1ns/1ns
`default_nettype none
module mic_integrity_bench;
   typedef struct packed {
      logic [31:0] evt;
      logic [23:0] q;
      logic [3:0]  lat;
      logic [7:0]  status;
   } mic_row_t;

   logic        clock, spi_sck, spi_cs_n, spi_si, spi_so, spi_so_oe;
   logic        resetn = 1'b0, deep_sleep = 1'b0, ecc_double_evt = 1'b0;
   logic        unit_query_err = 1'b0, mem_ack = 1'b0, mem_hold = 1'b0;
   logic [3:0]  read_latency_code = 4'h0;
   logic [31:0] ecc_double_unit_addr = 32'h0000_0000;
   logic [31:0] mem_word = 32'h0000_0000;
   logic        mem_req, write_latch_clr, double_bit_flag, op_in_progress;
   logic        checksum_abort_bit, checksum_paused_bit;
   logic [23:0] unit_query_addr, mem_addr;
   logic [15:0] double_error_count;
   logic [31:0] error_unit_address_trap, checksum_result;
   int          mismatches = 0, checks = 0, pulses = 0;
   mic_row_t    rows [4] = '{'{32'h0000_0148, 24'h00_0045, 4'h0, 8'h08},
                              '{32'h0000_0200, 24'h00_0047, 4'h3, 8'h08},
                              '{32'h0000_0308, 24'h00_0048, 4'hF, 8'h00},
                              '{32'h0000_0010, 24'h00_003F, 4'h1, 8'h00}};

   mic_integrity mic_integrity_inst (
      .clock, .resetn, .spi_sck, .spi_cs_n, .spi_si, .spi_so, .spi_so_oe,
      .read_latency_code, .deep_sleep, .ecc_double_evt,
      .ecc_double_unit_addr, .unit_query_addr, .unit_query_err, .mem_req,
      .mem_addr, .mem_word, .mem_ack, .write_latch_clr, .double_bit_flag,
      .double_error_count, .error_unit_address_trap, .checksum_result,
      .op_in_progress, .checksum_abort_bit, .checksum_paused_bit
   );
   mic_host_model mic_host_model_inst (
      .clock, .spi_sck, .spi_cs_n, .spi_si, .spi_so, .spi_so_oe
   );

   // Clock at 25 MHz
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   // Byte at address a is a xor 5Ah; byte a sits in bits 7:0
   function automatic logic [31:0] word_at(input logic [23:0] a);
      logic [7:0] b;
      b = a[7:0];
      return {b + 8'h03, b + 8'h02, b + 8'h01, b} ^ 32'h5A5A_5A5A;
   endfunction

   // Expected checksum of the words from first while not past last
   function automatic logic [31:0] crc_range(input int first, last);
      logic [31:0] c;
      logic [31:0] w;
      c = 32'h0000_0000;
      for (int a = first; a <= last; a += 4) begin
         w = word_at(24'(a));
         w = {w[7:0], w[15:8], w[23:16], w[31:24]};
         for (int i = 31; i >= 0; i--)
            c = {c[30:0], 1'b0} ^ ((c[31] ^ w[i]) ? `MIC_CRC_POLY : 32'h0);
      end
      return c;
   endfunction

   // Word store that can stall, unit error lookup, latch clear count
   always @(posedge clock) begin
      mem_ack <= mem_req && !mem_ack && !mem_hold;
      mem_word <= (mem_req && !mem_ack) ? word_at(mem_addr) : ~mem_word;
      unit_query_err <= (unit_query_addr == 24'h00_0040);
      if (write_latch_clr === 1'b1)
         pulses <= pulses + 1;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checks++;
      if (seen !== want) begin
         mismatches++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, want);
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Bounded wait for the busy and paused pair
   task automatic wait_for(input logic [1:0] want);
      int n;
      n = 0;
      while (n < 4000 && {op_in_progress, checksum_paused_bit} !== want) begin
         @(negedge clock);
         n++;
      end
      if (n == 4000) begin
         mismatches++;
         wrap_up();
      end
   endtask

   // Main sequence
   initial begin
      repeat (8) @(posedge clock);
      resetn <= 1'b1;
      repeat (6) @(posedge clock);
      @(negedge clock);
      check({16'h0, double_error_count}, 32'h0);
      check(checksum_result, 32'h0);
      foreach (rows[i]) begin
         @(posedge clock);
         ecc_double_evt <= 1'b1;
         ecc_double_unit_addr <= rows[i].evt;
         read_latency_code <= rows[i].lat;
         @(posedge clock);
         ecc_double_evt <= 1'b0;
         mic_host_model_inst.send({8'h19, rows[i].q, 32'h0}, 40 + i * 0
            + int'(rows[i].lat));
         @(negedge clock);
         check({24'h0, mic_host_model_inst.rx_byte}, {24'h0, rows[i].status});
         check({8'h0, unit_query_addr}, {8'h0, rows[i].q[23:3], 3'h0});
         check({16'h0, double_error_count}, 32'(i + 1));
         check(error_unit_address_trap, 32'h0000_0148);
         check({31'h0, double_bit_flag}, 32'h1);
      end
      @(posedge clock);
      ecc_double_evt <= 1'b1;
      repeat (65540) @(posedge clock);
      ecc_double_evt <= 1'b0;
      @(negedge clock);
      check({16'h0, double_error_count}, 32'h0000_FFFF);
      mic_host_model_inst.send({8'h1B, 56'h0}, 8);
      @(negedge clock);
      check({double_error_count, 15'h0, double_bit_flag}, 32'h0);
      check(error_unit_address_trap, 32'h0);
      mic_host_model_inst.send({8'h5B, 24'h00_0010, 24'h00_001B, 8'h0}, 56);
      wait_for(2'b00);
      check(checksum_result, crc_range(16, 27));
      @(negedge clock);
      check(32'(pulses), 32'h1);
      @(posedge clock);
      mem_hold <= 1'b1;
      mic_host_model_inst.send({8'h5B, 24'h00_0010, 24'h00_001B, 8'h0}, 55);
      @(negedge clock);
      check({31'h0, op_in_progress}, 32'h0);
      mic_host_model_inst.send({8'h5B, 24'h00_0003, 24'h00_0022, 8'h0}, 56);
      @(negedge clock);
      check({30'h0, op_in_progress, checksum_paused_bit}, 32'h2);
      check(checksum_result, 32'h0);
      mic_host_model_inst.send({8'h75, 56'h0}, 8);
      mem_hold <= 1'b0;
      wait_for(2'b01);
      check({30'h0, op_in_progress, checksum_paused_bit}, 32'h1);
      mic_host_model_inst.send({8'h7A, 56'h0}, 8);
      wait_for(2'b00);
      check(checksum_result, crc_range(3, 34));
      @(negedge clock);
      check(32'(pulses), 32'h2);
      @(posedge clock);
      ecc_double_evt <= 1'b1;
      @(posedge clock);
      ecc_double_evt <= 1'b0;
      deep_sleep <= 1'b1;
      repeat (4) @(posedge clock);
      deep_sleep <= 1'b0;
      repeat (2) @(posedge clock);
      @(negedge clock);
      check({16'h0, double_error_count}, 32'h0);
      check(error_unit_address_trap, 32'h0);
      check(checksum_result, 32'h0);
      mic_host_model_inst.send({8'h5B, 24'h00_0040, 24'h00_0042, 8'h0}, 56);
      wait_for(2'b00);
      check({31'h0, checksum_abort_bit}, 32'h1);
      mic_host_model_inst.send({8'h7A, 56'h0}, 8);
      @(negedge clock);
      check({30'h0, op_in_progress, checksum_paused_bit}, 32'h0);
      // Reset with the checksum engine idle wipes a fresh detection
      @(posedge clock);
      ecc_double_evt <= 1'b1;
      @(posedge clock);
      ecc_double_evt <= 1'b0;
      resetn <= 1'b0;
      repeat (2) @(posedge clock);
      resetn <= 1'b1;
      repeat (4) @(posedge clock);
      @(negedge clock);
      check({15'h0, double_bit_flag, double_error_count}, 32'h0);
      check(error_unit_address_trap, 32'h0);
      wrap_up();
   end
endmodule
`default_nettype wire

// File: mic_integrity_monitor.sv
/*
   Checker of mic_integrity ports: error tracking, deep sleep, run end.
   Assumes the bind below reaches every mic_integrity instance.
*/
`timescale 1ns/1ns
`default_nettype none
module mic_integrity_monitor (
   input wire logic        clock,                   // Clock
   input wire logic        resetn,                  // Reset, low
   input wire logic        spi_cs_n,                // Select, low
   input wire logic        spi_so_oe,               // Out enable
   input wire logic        deep_sleep,              // Sleep level
   input wire logic        ecc_double_evt,          // Detection
   input wire logic [31:0] ecc_double_unit_addr,    // Its unit
   input wire logic        write_latch_clr,         // Latch clear
   input wire logic        double_bit_flag,         // Flag
   input wire logic [15:0] double_error_count,      // Counter
   input wire logic [31:0] error_unit_address_trap, // Trap
   input wire logic [31:0] checksum_result,         // Checksum
   input wire logic        op_in_progress           // Busy
);
   // One clock domain; reset disables every check
   default clocking mon_cb @(posedge clock);
   endclocking
   default disable iff (!resetn);

   property p_flag_set;
      ecc_double_evt |=> double_bit_flag;
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("flag not set");

   property p_count_inc;
      ecc_double_evt && double_error_count != 16'hFFFF |=>
         double_error_count == $past(double_error_count) + 16'h0001
         || double_error_count == 16'h0001;
   endproperty
   a_count_inc: assert property (p_count_inc)
      else $error("count did not step");

   property p_count_sat;
      ecc_double_evt && double_error_count == 16'hFFFF |=>
         double_error_count inside {16'hFFFF, 16'h0001};
   endproperty
   a_count_sat: assert property (p_count_sat)
      else $error("count wrapped");

   property p_sleep_zero;
      deep_sleep && !ecc_double_evt ##1 deep_sleep && !ecc_double_evt
         ##1 deep_sleep |-> double_error_count == 16'h0000
         && error_unit_address_trap == 32'h0000_0000
         && checksum_result == 32'h0000_0000;
   endproperty
   a_sleep_zero: assert property (p_sleep_zero)
      else $error("sleep kept state");

   property p_trap_first;
      !double_bit_flag && ecc_double_evt |=>
         error_unit_address_trap == $past(ecc_double_unit_addr);
   endproperty
   a_trap_first: assert property (p_trap_first)
      else $error("trap missed first unit");

   property p_trap_keep;
      double_bit_flag && !deep_sleep |=>
         error_unit_address_trap == $past(error_unit_address_trap)
         || error_unit_address_trap == 32'h0000_0000;
   endproperty
   a_trap_keep: assert property (p_trap_keep)
      else $error("trap overwritten");

   property p_latch_done;
      write_latch_clr |-> !op_in_progress && $past(op_in_progress);
   endproperty
   a_latch_done: assert property (p_latch_done)
      else $error("latch clear off run end");

   property p_oe_idle;
      spi_cs_n [*4] |-> !spi_so_oe;
   endproperty
   a_oe_idle: assert property (p_oe_idle)
      else $error("output driven while deselected");
endmodule
bind mic_integrity mic_integrity_monitor mic_integrity_monitor_inst (
   .clock, .resetn, .spi_cs_n, .spi_so_oe, .deep_sleep, .ecc_double_evt,
   .ecc_double_unit_addr, .write_latch_clr, .double_bit_flag,
   .double_error_count, .error_unit_address_trap, .checksum_result,
   .op_in_progress
);
`default_nettype wire

// File: mic_params.svh
/*
   Constants of the memory integrity block: opcodes, frame lengths,
   field positions, reset values and the checksum generator.
   Assumes inclusion by bare name from the bench and the design file.
*/
`ifndef MIC_PARAMS_SVH
`define MIC_PARAMS_SVH

// Opcodes taken from the serial link
`define MIC_OP_UNIT_QUERY      8'h19
`define MIC_OP_CLEAR           8'h1B
`define MIC_OP_RUN             8'h5B
`define MIC_OP_PAUSE           8'h75
`define MIC_OP_CONTINUE        8'h7A

// Frame lengths in link bits, counted from chip select falling
`define MIC_CMD_BITS           6'd8
`define MIC_QUERY_BITS         6'd32
`define MIC_RUN_BITS           6'd56
`define MIC_BIT_CNT_MAX        6'd63
`define MIC_ADDR_BITS          24

// Unit status byte layout and unit address alignment
`define MIC_UNIT_ERR_BIT       3
`define MIC_UNIT_LSB_BITS      3

// Reset values of the result registers and the counter limit
`define MIC_DEC_RESET          16'h0000
`define MIC_DEC_MAX            16'hFFFF
`define MIC_TRAP_RESET         32'h0000_0000
`define MIC_CRC_RESET          32'h0000_0000

// Checksum generator and range arithmetic
`define MIC_CRC_POLY           32'h1EDC_6F41
`define MIC_RANGE_MIN          25'h000_0003
`define MIC_WORD_STEP          25'h000_0004

`endif

// File: mic_pkg.sv
/*
   Types of the memory integrity block.
   Assumes mic_params.svh is reachable on the include path.
*/
`default_nettype none
package mic_pkg;
   // Link command decoder states
   typedef enum logic [2:0] {
      MIC_SPI_CMD,
      MIC_SPI_ADDR,
      MIC_SPI_DUMMY,
      MIC_SPI_DOUT,
      MIC_SPI_IGNORE
   } mic_spi_state_t;

   // Checksum engine states
   typedef enum logic [1:0] {
      MIC_CRC_IDLE,
      MIC_CRC_FETCH,
      MIC_CRC_PAUSE
   } mic_crc_state_t;
endpackage
`default_nettype wire
